// [hw/sbif_front_end.sv]
/*
  Two-channel serial bus interface front end: AXI4-Lite register slave,
  per-channel register sets, pin control and link-clock shift engines.
  Assumes the address is the offset from the block base and that
  two-way pins are resolved outside from the output enables.
*/
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module sbif_front_end import sbif_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic [SBIF_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [SBIF_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] scl_i,
  output logic [1:0] scl_o,
  output logic [1:0] scl_oe,
  input wire logic [1:0] sda_i,
  output logic [1:0] sda_o,
  output logic [1:0] sda_oe,
  output logic [1:0] sck_o,
  output logic [1:0] sck_oe,
  input wire logic [1:0] si_i,
  output logic [1:0] so_o,
  output logic [1:0] so_oe
);
  logic [SBIF_AW-1:0] aw_addr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic write_go;
  logic [1:0] en_r;
  logic [7:0] cr1_r [2];
  logic [7:0] dbr_r [2];
  logic [7:0] oar_r [2];
  logic [7:0] cr2_r [2];
  logic [7:0] br0_r [2];
  logic [7:0] rx_hold_r [2];
  logic [1:0] start_tgl_r;
  logic [1:0] done_seen_r;
  logic [1:0] done_s;
  logic [1:0] busy;
  logic [3:0] pins_s;
  logic [31:0] rd_word;
  logic [4:0] a_last_off_r;

  ////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Channel select and mapped offset check, shared by reads and writes
  function automatic logic sbif_hit(input logic [SBIF_AW-1:0] a);
    logic [4:0] off;
    off = a[4:0];
    sbif_hit = (a[SBIF_AW-1:6] == '0) && (off[1:0] == 2'h0) &&
               (off <= SBIF_OFF_BR0);
  endfunction

  function automatic logic sbif_chan(input logic [SBIF_AW-1:0] a);
    sbif_chan = (a & SBIF_CH_STRIDE) != '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order

  assign write_go = !awready && !wready && !bvalid;

  // Address slot; ready drops while an address waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      aw_addr_r <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr_r <= awaddr;
    end else if (write_go) begin
      awready <= 1'b1;
    end
  end

  // Data slot; only the low lane carries register bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wready <= 1'b1;
      wdata_r <= SBIF_REG_RST;
      wlane_r <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wdata_r <= wdata[7:0];
      wlane_r <= wstrb[0];
    end else if (write_go) begin
      wready <= 1'b1;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= SBIF_RESP_OKAY;
    end else if (write_go) begin
      bvalid <= 1'b1;
      bresp <= sbif_hit(aw_addr_r) ? SBIF_RESP_OKAY : SBIF_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel registers and link crossing

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      sbif_link_if lnk ();
      logic wr_me;
      logic [4:0] woff;

      assign woff = aw_addr_r[4:0];
      assign wr_me = write_go && wlane_r && sbif_hit(aw_addr_r) &&
                     (sbif_chan(aw_addr_r) == 1'(g));

      // Enable bit lives on its own; reserved bits have no storage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          en_r[g] <= 1'b0;
        end else if (wr_me && woff == SBIF_OFF_CR0) begin
          en_r[g] <= wdata_r[SBIF_EN_BIT];
        end
      end

      // Other registers load only while enabled and hold otherwise
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cr1_r[g] <= SBIF_REG_RST;
          dbr_r[g] <= SBIF_REG_RST;
          oar_r[g] <= SBIF_REG_RST;
          cr2_r[g] <= SBIF_REG_RST;
          br0_r[g] <= SBIF_REG_RST;
          start_tgl_r[g] <= 1'b0;
        end else if (wr_me && en_r[g]) begin
          unique case (woff)
            SBIF_OFF_CR1: cr1_r[g] <= wdata_r;
            SBIF_OFF_OAR: oar_r[g] <= wdata_r;
            SBIF_OFF_CR2_SR: cr2_r[g] <= wdata_r;
            SBIF_OFF_BR0: br0_r[g] <= wdata_r;
            SBIF_OFF_DBR: begin
              // A busy shifter would see its word change; drop the write
              if (!busy[g]) begin
                dbr_r[g] <= wdata_r;
                if (cr2_r[g][SBIF_MODE_BIT]) begin
                  start_tgl_r[g] <= ~start_tgl_r[g];
                end
              end
            end
            default: begin
            end
          endcase
        end
      end

      sbif_sync #(.W(1)) u_done (
        .clk(clk),
        .rst(rst),
        .d(lnk.done_tgl),
        .q(done_s[g])
      );

      // Received word is stable by the time the done toggle arrives
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          done_seen_r[g] <= 1'b0;
          rx_hold_r[g] <= SBIF_REG_RST;
        end else if (done_s[g] != done_seen_r[g]) begin
          done_seen_r[g] <= done_s[g];
          rx_hold_r[g] <= lnk.rx_byte;
        end
      end

      assign busy[g] = start_tgl_r[g] != done_seen_r[g];
      assign lnk.start_tgl = start_tgl_r[g];
      assign lnk.tx_byte = dbr_r[g];
      assign lnk.shift_mode = cr2_r[g][SBIF_MODE_BIT];
      assign lnk.enable = en_r[g];

      sbif_shift_engine u_eng (
        .link_clk(link_clk),
        .rst(rst),
        .lnk(lnk),
        .si_i(si_i[g]),
        .sck_o(sck_o[g]),
        .so_o(so_o[g])
      );

      // Pin ownership follows the mode bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          scl_o[g] <= 1'b0;
          sda_o[g] <= 1'b0;
          scl_oe[g] <= 1'b0;
          sda_oe[g] <= 1'b0;
          sck_oe[g] <= 1'b0;
          so_oe[g] <= 1'b0;
        end else begin
          scl_o[g] <= 1'b0;
          sda_o[g] <= 1'b0;
          // Open drain: only ever pull low, never drive high
          scl_oe[g] <= en_r[g] && !cr2_r[g][SBIF_MODE_BIT] &&
                       cr1_r[g][SBIF_SCL_HOLD_BIT];
          sda_oe[g] <= en_r[g] && !cr2_r[g][SBIF_MODE_BIT] &&
                       cr1_r[g][SBIF_SDA_HOLD_BIT];
          sck_oe[g] <= en_r[g] && cr2_r[g][SBIF_MODE_BIT];
          so_oe[g] <= en_r[g] && cr2_r[g][SBIF_MODE_BIT];
        end
      end

      // Two-wire pins never driven in shift mode
      a_twowire_off: assert property (@(posedge clk) disable iff (rst)
        cr2_r[g][SBIF_MODE_BIT] |=> !scl_oe[g] && !sda_oe[g])
        else $error("two-wire pin driven in shift mode");

      // Settings survive a disable
      a_retain_cfg: assert property (@(posedge clk) disable iff (rst)
        !en_r[g] |=> $stable(cr1_r[g]) && $stable(cr2_r[g]) &&
        $stable(br0_r[g]))
        else $error("register changed while channel disabled");

      sequence s_start;
        wr_me && en_r[g] && woff == SBIF_OFF_DBR && !busy[g] &&
        cr2_r[g][SBIF_MODE_BIT];
      endsequence

      // Shift mode data write starts a transfer at once
      a_shift_start: assert property (@(posedge clk) disable iff (rst)
        s_start |=> busy[g] ##1 busy[g])
        else $error("data write did not start shift transfer");

      // Word under transfer may not change until the engine hands back
      a_dbr_hold: assert property (@(posedge clk) disable iff (rst)
        busy[g] |=> $stable(dbr_r[g]))
        else $error("data buffer changed during shift transfer");

      // Shift pins enabled one edge after entering shift mode enabled
      a_shift_pins: assert property (@(posedge clk) disable iff (rst)
        $rose(en_r[g] && cr2_r[g][SBIF_MODE_BIT]) |-> ##1 sck_oe[g] && so_oe[g])
        else $error("shift pins not enabled");
    end
  endgenerate

  sbif_sync #(.W(4)) u_pins (
    .clk(clk),
    .rst(rst),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  // Read mux; offset 0x10 returns status, not control two
  always_comb begin
    logic c;
    c = sbif_chan(araddr);
    rd_word = 32'h0000_0000;
    unique case (araddr[4:0])
      SBIF_OFF_CR0: rd_word[SBIF_EN_BIT] = en_r[c];
      SBIF_OFF_CR1: rd_word[7:0] = cr1_r[c];
      SBIF_OFF_DBR: rd_word[7:0] = rx_hold_r[c];
      SBIF_OFF_OAR: rd_word[7:0] = oar_r[c];
      SBIF_OFF_CR2_SR: begin
        rd_word[SBIF_ST_BUSY] = busy[c];
        rd_word[SBIF_ST_MODE] = cr2_r[c][SBIF_MODE_BIT];
        rd_word[SBIF_ST_SDA] = pins_s[c];
        rd_word[SBIF_ST_SCL] = pins_s[2 + 32'(c)];
        rd_word[SBIF_ST_EN] = en_r[c];
      end
      SBIF_OFF_BR0: rd_word[7:0] = br0_r[c];
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // One read at a time; address ready reopens after the data is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= SBIF_RESP_OKAY;
      a_last_off_r <= 5'h00;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      a_last_off_r <= araddr[4:0];
      rdata <= sbif_hit(araddr) ? rd_word : 32'h0000_0000;
      rresp <= sbif_hit(araddr) ? SBIF_RESP_OKAY : SBIF_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus-level checks

  sequence s_ar_take;
    arvalid && arready;
  endsequence

  sequence s_r_hold;
    rvalid && !arready;
  endsequence

  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    s_ar_take |=> s_r_hold)
    else $error("read not answered in one cycle");

  a_write_answer: assert property (@(posedge clk) disable iff (rst)
    write_go |=> bvalid && awready && wready)
    else $error("write not answered in one cycle");

  a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
    s_ar_take and !sbif_hit(araddr) |=> rresp == SBIF_RESP_SLVERR)
    else $error("unmapped read without error");

  a_cr0_zeros: assert property (@(posedge clk) disable iff (rst)
    rvalid && a_last_off_r == SBIF_OFF_CR0 |->
    rdata[31:8] == 24'h0 && rdata[6:0] == 7'h0)
    else $error("reserved control zero bits read nonzero");

  a_reset_en: assert property (@(posedge clk)
    rst |=> en_r == 2'h0)
    else $error("enable not cleared by reset");

  a_en_write: assert property (@(posedge clk) disable iff (rst)
    write_go && wlane_r && aw_addr_r == 8'h00 |=>
    en_r[0] == wdata_r[SBIF_EN_BIT])
    else $error("enable bit write not taken");
endmodule

// [hw/sbif_link_if.sv]
/*
  Carrier between the bus-side registers and one link-side shift engine.
  Assumes each signal is driven in one clock domain only.
*/
`timescale 1ns/100ps
interface sbif_link_if;
  logic start_tgl;
  logic [7:0] tx_byte;
  logic shift_mode;
  logic enable;
  logic done_tgl;
  logic [7:0] rx_byte;
  modport bus (output start_tgl, tx_byte, shift_mode, enable, input done_tgl, rx_byte);
  modport link (input start_tgl, tx_byte, shift_mode, enable, output done_tgl, rx_byte);
endinterface

// [hw/sbif_pkg.sv]
/*
  Shared constants for the two-channel serial bus interface front end.
  Assumes an AXI4-Lite master in front and a 25 MHz bus clock.
*/
package sbif_pkg;
  localparam int SBIF_AW = 8;
  localparam logic [7:0] SBIF_CH_STRIDE = 8'h20;
  localparam logic [4:0] SBIF_OFF_CR0 = 5'h00;
  localparam logic [4:0] SBIF_OFF_CR1 = 5'h04;
  localparam logic [4:0] SBIF_OFF_DBR = 5'h08;
  localparam logic [4:0] SBIF_OFF_OAR = 5'h0c;
  localparam logic [4:0] SBIF_OFF_CR2_SR = 5'h10;
  localparam logic [4:0] SBIF_OFF_BR0 = 5'h14;
  localparam int SBIF_EN_BIT = 7;
  localparam int SBIF_MODE_BIT = 0;
  localparam int SBIF_SCL_HOLD_BIT = 1;
  localparam int SBIF_SDA_HOLD_BIT = 0;
  localparam int SBIF_ST_BUSY = 0;
  localparam int SBIF_ST_MODE = 1;
  localparam int SBIF_ST_SDA = 2;
  localparam int SBIF_ST_SCL = 3;
  localparam int SBIF_ST_EN = 7;
  localparam logic [7:0] SBIF_REG_RST = 8'h00;
  localparam logic [1:0] SBIF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBIF_RESP_SLVERR = 2'h2;
  localparam logic [2:0] SBIF_LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    SBIF_IDLE = 3'b001,
    SBIF_LOW = 3'b010,
    SBIF_HIGH = 3'b100
  } sbif_shift_state_type;
endpackage

// [hw/sbif_shift_engine.sv]
/*
  Link-clock shift engine for one channel: 8 bits, MSB first.
  Assumes the tx byte is held steady from start toggle to done toggle.
*/
`timescale 1ns/100ps
module sbif_shift_engine import sbif_pkg::*; (
  input wire logic link_clk,
  input wire logic rst,
  sbif_link_if.link lnk,
  input wire logic si_i,
  output logic sck_o,
  output logic so_o
);
  logic [3:0] lvl_s;
  logic start_seen_r;
  logic done_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_r;
  logic [2:0] cnt_r;
  sbif_shift_state_type st_r;

  sbif_sync #(.W(4)) u_sync (
    .clk(link_clk),
    .rst(rst),
    .d({lnk.shift_mode, lnk.start_tgl, lnk.enable, si_i}),
    .q(lvl_s)
  );

  assign lnk.done_tgl = done_r;
  assign lnk.rx_byte = rx_r;

  ////////////////////////////////////////////////////////////////////////
  // Shift sequencer; a cleared enable freezes it like a stopped clock
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      st_r <= SBIF_IDLE;
      start_seen_r <= 1'b0;
      done_r <= 1'b0;
      tx_sh_r <= SBIF_REG_RST;
      rx_r <= SBIF_REG_RST;
      cnt_r <= 3'h0;
      sck_o <= 1'b0;
      so_o <= 1'b0;
    end else if (lvl_s[1]) begin
      unique case (st_r)
        SBIF_IDLE: begin
          sck_o <= 1'b0;
          if (lvl_s[2] != start_seen_r) begin
            start_seen_r <= lvl_s[2];
            if (lvl_s[3]) begin
              tx_sh_r <= lnk.tx_byte;
              cnt_r <= 3'h0;
              st_r <= SBIF_LOW;
            end else begin
              // Mode left before the start arrived; hand back so busy clears
              done_r <= ~done_r;
            end
          end
        end
        SBIF_LOW: begin
          sck_o <= 1'b0;
          so_o <= tx_sh_r[7];
          st_r <= SBIF_HIGH;
        end
        SBIF_HIGH: begin
          sck_o <= 1'b1;
          rx_r <= {rx_r[6:0], lvl_s[0]};
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == SBIF_LAST_BIT) begin
            done_r <= ~done_r;
            st_r <= SBIF_IDLE;
          end else begin
            st_r <= SBIF_LOW;
          end
        end
      endcase
    end
  end

  // Clock high follows every low phase
  a_sck_phase: assert property (@(posedge link_clk) disable iff (rst)
    (st_r == SBIF_LOW && lvl_s[1]) |=> sck_o == 1'b0 && st_r == SBIF_HIGH)
    else $error("shift low phase not followed by high phase");
endmodule

// [hw/sbif_sync.sv]
/*
  Two-flop level synchroniser, W bits wide.
  Assumes each bit is a level or toggle that is stable for several edges.
*/
`timescale 1ns/100ps
module sbif_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// [tb/sbif_peer.sv]
/*
  Far-side clocked serial peer for one channel in shift mode.
  Assumes the shift clock idles low and so is steady at each rise.
*/
`timescale 1ns/100ps
module sbif_peer (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic sel,
  input wire logic so,
  input wire logic [7:0] pat,
  output logic si,
  output logic [7:0] cap,
  output logic [7:0] nbit
);
  logic [2:0] idx;
  logic junk;
  ////////////////////////////////////////////////////////////////
  // Capture MSB first on each rising shift clock
  always @(posedge sck or posedge rst) begin
    if (rst) begin
      cap <= 8'h00;
      nbit <= 8'h00;
    end else begin
      cap <= {cap[6:0], so};
      nbit <= nbit + 8'h01;
    end
  end
  // Next bit goes out after the falling clock edge
  always @(negedge sck or posedge rst) begin
    if (rst) idx <= 3'h7;
    else idx <= idx - 3'h1;
  end
  // Unselected line toggles so a stale bit cannot pass
  always @(posedge link_clk or posedge rst) begin
    if (rst) junk <= 1'b0;
    else junk <= ~junk;
  end
  assign si = sel ? pat[idx] : junk;
endmodule

// [tb/test_serial_bus_if_front_end.sv]
/*
  Self-checking bench for the serial bus front end.
  Assumes pull-ups on the two-wire lines and one shift peer per channel.
*/
`timescale 1ns/100ps
module test_serial_bus_if_front_end;
  import sbif_pkg::*;
  typedef struct {logic [31:0] d; logic [1:0] r; logic m;} sbif_note_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] ws = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, scl_o, scl_oe, sda_o, sda_oe, sck_o, sck_oe, so_o, so_oe;
  logic [1:0] scl_i, sda_i;
  wire [1:0] si_i;
  logic [31:0] rdata, rdv, tx;
  logic [7:0] pat [2] = '{8'h00, 8'h00};
  logic [7:0] cap [2];
  logic [7:0] nb [2];
  logic [7:0] v [2][3];
  logic [7:0] nb0;
  int po [3] = '{4, 12, 20};
  int ro [5] = '{0, 4, 8, 12, 20};
  int n_mismatch = 0;
  int n_compared = 0;
  sbif_note_type rq [$];
  sbif_note_type nt;
  logic [1:0] bq [$];

  ////////////////////////////////////////////////////////////////
  // Clocks unrelated in phase
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // Open-drain lines with pull-ups
  assign scl_i = ~scl_oe;
  assign sda_i = ~sda_oe;

  sbif_front_end DUT (.clk, .rst, .link_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .sck_o,
    .sck_oe, .si_i, .so_o, .so_oe);
  for (genvar c = 0; c < 2; c++) begin : g_peer
    sbif_peer P (.link_clk, .rst, .sck(sck_o[c]), .sel(sck_oe[c]), .so(so_o[c]),
      .pat(pat[c]), .si(si_i[c]), .cap(cap[c]), .nbit(nb[c]));
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wrap_up;
    $display("Counts: compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad, wd;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(e);
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
  endtask
  // Read: m low means the answer is only kept in rdv
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
    input logic m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back(sbif_note_type'{e, r, m});
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rdv = rdata;
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  // Oldest note is popped whenever an answer is handed over; read notes with m low are not checked
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) begin
      chk("bresp", bq.pop_front(), bresp);
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
      nt = rq.pop_front();
      if (nt.m) begin
        chk("rdata", nt.d, rdata);
        chk("rresp", nt.r, rresp);
      end
    end
  end
  // Whole run needs well under 5000 cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    void'($urandom(73));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ro[k]) rd(8'(ro[k]), 32'h0, SBIF_RESP_OKAY, 1'b1);
    foreach (ro[k]) rd(8'(ro[k] + 32), 32'h0, SBIF_RESP_OKAY, 1'b1);
    $display("Test reset values done");
    // Disabled channel ignores all but control zero
    wr(8'h04, $urandom, SBIF_RESP_OKAY);
    rd(8'h04, 32'h0, SBIF_RESP_OKAY, 1'b1);
    wr(8'h00, 32'hffffffff, SBIF_RESP_OKAY);
    rd(8'h00, 32'h80, SBIF_RESP_OKAY, 1'b1);
    rd(8'h20, 32'h0, SBIF_RESP_OKAY, 1'b1);
    wr(8'h20, 32'h00000080, SBIF_RESP_OKAY);
    $display("Test enable and reserved bits done");
    for (int c = 0; c < 2; c++)
      foreach (po[k]) begin
        v[c][k] = 8'($urandom);
        wr(8'(c * 32 + po[k]), {24'($urandom), v[c][k]}, SBIF_RESP_OKAY);
      end
    for (int c = 0; c < 2; c++)
      foreach (po[k]) rd(8'(c * 32 + po[k]), {24'h0, v[c][k]}, SBIF_RESP_OKAY, 1'b1);
    // A write with the low lane off leaves the register alone
    ws = 4'he;
    wr(8'h04, {24'h0, ~v[0][0]}, SBIF_RESP_OKAY);
    ws = 4'hf;
    rd(8'h04, {24'h0, v[0][0]}, SBIF_RESP_OKAY, 1'b1);
    // Disable keeps settings and freezes writes
    wr(8'h00, 32'h0, SBIF_RESP_OKAY);
    wr(8'h0c, 32'h0, SBIF_RESP_OKAY);
    foreach (po[k]) rd(8'(po[k]), {24'h0, v[0][k]}, SBIF_RESP_OKAY, 1'b1);
    wr(8'h00, 32'h80, SBIF_RESP_OKAY);
    $display("Test register map and retention done");
    for (int c = 0; c < 2; c++) begin
      // Two-wire mode: hold bits pull both lines low
      wr(8'(c * 32 + 16), 32'h0, SBIF_RESP_OKAY);
      wr(8'(c * 32 + 4), 32'h3, SBIF_RESP_OKAY);
      repeat (4) @(posedge clk);
      chk("line_oe", 32'h3, {scl_oe[c], sda_oe[c]});
      chk("line_o", 32'h0, {scl_o[c], sda_o[c], sck_oe[c], so_oe[c]});
      rd(8'(c * 32 + 16), 32'h80, SBIF_RESP_OKAY, 1'b1);
      wr(8'(c * 32 + 4), 32'h0, SBIF_RESP_OKAY);
      repeat (4) @(posedge clk);
      rd(8'(c * 32 + 16), 32'h8c, SBIF_RESP_OKAY, 1'b1);
      // Shift mode: three pins, 8 bits per word
      wr(8'(c * 32 + 16), 32'h1, SBIF_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("shift_oe", 32'h3, {sck_oe[c], so_oe[c]});
      chk("line_oe_off", 32'h0, {scl_oe[c], sda_oe[c]});
      rd(8'(c * 32 + 16), 32'h8e, SBIF_RESP_OKAY, 1'b1);
      for (int n = 0; n < 2; n++) begin
        pat[c] = n ? 8'h00 : 8'hff;
        tx = 32'($urandom);
        nb0 = nb[c];
        wr(8'(c * 32 + 8), tx, SBIF_RESP_OKAY);
        for (int i = 0; i < 100; i++) begin
          rd(8'(c * 32 + 16), 32'h0, SBIF_RESP_OKAY, 1'b0);
          if (rdv[SBIF_ST_BUSY] === 1'b0) break;
        end
        chk("peer_byte", {24'h0, tx[7:0]}, {24'h0, cap[c]});
        chk("peer_bits", 32'(nb0 + 8'h08), 32'(nb[c]));
        rd(8'(c * 32 + 8), {24'h0, pat[c]}, SBIF_RESP_OKAY, 1'b1);
      end
    end
    $display("Test pin modes and shift transfers done");
    rd(8'h18, 32'h0, SBIF_RESP_SLVERR, 1'b1);
    wr(8'h1c, $urandom, SBIF_RESP_SLVERR);
    rd(8'h40, 32'h0, SBIF_RESP_SLVERR, 1'b1);
    rd(8'h00, 32'h80, SBIF_RESP_OKAY, 1'b1);
    $display("Test unmapped access done");
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
